// ==== hw/phy_regs_defs.svh ====
// Offsets, field positions, reset values and timing for the mode and auxiliary register bank.
// Operation
// RULE_01: Receive error counting stops while the counter-disable bit 13 is set; resets 0.
// RULE_02: Negotiation-complete flag reads in line-coding bit 12 and aux status bit 15.
// RULE_03: DC restoration applies while line-coding bit 8 is one; resets 1.
// RULE_04: NRZ/NRZI conversion applies while line-coding bit 7 is one; resets 1.
// RULE_05: Transmit isolation bit 5 separates MAC interface from line pair; resets 0.
// RULE_06: Read-only bits 4:2 show the current operating mode code.
// RULE_07: Line-coding bit 1 disables the three-level encoder and decoder; resets 0.
// RULE_08: Bit 0 bypasses the scrambler; fibre mode always bypasses it.
// RULE_09: Management address bits 7:3 are writable and loaded from straps at reset.
// RULE_10: Receiver mode bit 1 accepts frames without preamble; resets 1.
// RULE_11: Jabber cutoff applies in 10 Mb/s twisted pair unless aux control bit 15.
// RULE_12: Writing zero or chip reset restores jabber protection; reads return stored bit.
// RULE_13: Aux control bit 4 gates the management clock while idle; resets 0.
// RULE_14: Aux status bit 14 latches when negotiation completes acknowledge state.
// RULE_15: Aux status bit 13 latches when negotiation enters acknowledge after a match.
// RULE_16: Aux status bit 12 latches while negotiation is in ability detect.
// RULE_17: Pause bit 11 only after negotiation completes with symmetric pause both sides.
// RULE_18: Bits 10:8 report the negotiated highest common mode.
// RULE_19: Latching flags stay set until read while their condition has gone.
// RULE_20: Fibre mode disables auto-negotiation and scrambling.
// RULE_21: Management frames are answered only when their address matches the stored one.
// RULE_22: Reserved fields read their defaults; writes to read-only fields are ignored.
`ifndef PHY_REGS_DEFS_SVH
`define PHY_REGS_DEFS_SVH

`define LINE_CODING_ADDR   5'h13
`define RX_MODE_ADDR       5'h14
`define AUX_CTRL_ADDR      5'h18
`define AUX_STATUS_ADDR    5'h19

`define LC_RXERR_DIS_BIT   13
`define LC_AN_DONE_BIT     12
`define LC_DC_REST_BIT     8
`define LC_NRZI_BIT        7
`define LC_TX_ISO_BIT      5
`define LC_MODE_LSB        2
`define LC_MLT3_DIS_BIT    1
`define LC_SCR_DIS_BIT     0
`define LC_RESET           16'h01C0
`define LC_RW_MASK         16'h2FE3

`define RM_ADDR_LSB        3
`define RM_PRE_SUP_BIT     1
`define RM_RESET           16'h0002
`define RM_RW_MASK         16'h08FA

`define AC_JAB_DIS_BIT     15
`define AC_MDIO_PS_BIT     4
`define AC_RESET           16'h0027
`define AC_RW_MASK         16'hC0F0

`define AS_AN_DONE_BIT     15
`define AS_AN_ACK_BIT      14
`define AS_AN_MATCH_BIT    13
`define AS_AN_ABIL_BIT     12
`define AS_PAUSE_BIT       11
`define AS_HCM_LSB         8

`define MDIO_PREAMBLE_BITS 32
`define MDIO_IDLE_CYCLES   8'h40

`endif

// ==== hw/phy_regs_pkg.sv ====
// Mode and common-mode code types for the register bank; the serial engine keeps its own state type.
package phy_regs_pkg;
  typedef enum logic [2:0] {
    MODE_NEGOTIATING, MODE_10_HALF, MODE_100_HALF, MODE_UNUSED_3,
    MODE_UNUSED_4, MODE_10_FULL, MODE_100_FULL, MODE_TX_ISOLATE
  } op_mode_type;
  typedef enum logic [2:0] {
    HCM_NONE, HCM_10_HALF, HCM_10_FULL, HCM_100_HALF, HCM_RSVD_4, HCM_100_FULL,
    HCM_RSVD_6, HCM_RSVD_7
  } hcm_type;
endpackage

// ==== hw/mdio_serial_engine.sv ====
// Management serial frame engine: samples the link clock and data, decodes frames.
`timescale 1ns/1ps
`include "phy_regs_defs.svh"
module mdio_serial_engine (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        mdc_pin,
  input  wire logic        mdio_in_pin,
  input  wire logic [4:0]  mgmt_station_address,
  input  wire logic        preamble_suppress,
  input  wire logic        clock_gate_en,
  input  wire logic [15:0] rd_data,
  output logic             rd_strobe,
  output logic             wr_strobe,
  output logic [4:0]       reg_addr,
  output logic [15:0]      wr_data,
  output logic             mdio_out,
  output logic             mdio_oe,
  output logic             mdc_active
);
  typedef enum logic [2:0] {S_PRE, S_START, S_HEAD, S_TA, S_DATA} frame_state_type;

  logic [2:0]  mdc_sync_reg;
  logic [1:0]  mdio_sync_reg;
  logic        mdc_rise;
  logic        mdc_fall;
  logic        bit_in;
  frame_state_type state_reg;
  logic [5:0]  pre_cnt_reg;
  logic [4:0]  bit_cnt_reg;
  logic [13:0] head_reg;
  logic [15:0] shift_reg;
  logic        read_op_reg;
  logic        match_reg;
  logic [7:0]  idle_cnt_reg;

  // Two flops per pin; a third mdc flop feeds edge finding.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mdc_sync_reg  <= 3'h0;
      mdio_sync_reg <= 2'h3;
    end else begin
      mdc_sync_reg  <= {mdc_sync_reg[1:0], mdc_pin};
      mdio_sync_reg <= {mdio_sync_reg[0], mdio_in_pin};
    end
  end
  assign bit_in = mdio_sync_reg[1];

  // With power saving on, rising clock edges are ignored after a quiet spell.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      idle_cnt_reg <= 8'h00;
      mdc_active   <= 1'b1;
    end else if (!bit_in || state_reg != S_PRE) begin
      idle_cnt_reg <= 8'h00;
      mdc_active   <= 1'b1;
    end else if (idle_cnt_reg != `MDIO_IDLE_CYCLES) begin
      idle_cnt_reg <= idle_cnt_reg + 8'h01;
    end else begin
      mdc_active   <= !clock_gate_en; // [RULE_13]
    end
  end
  // A frame start (data low) wakes the gate, so preamble bits seen while it sleeps are not counted.
  assign mdc_rise = mdc_sync_reg[1] && !mdc_sync_reg[2] && mdc_active;
  assign mdc_fall = !mdc_sync_reg[1] && mdc_sync_reg[2];

  // Frame decode on rising clock edges; a bad start or opcode returns to preamble hunt.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= S_PRE;
      pre_cnt_reg <= 6'h00;
      bit_cnt_reg <= 5'h00;
      head_reg    <= 14'h0000;
      shift_reg   <= 16'h0000;
      read_op_reg <= 1'b0;
      match_reg   <= 1'b0;
      rd_strobe   <= 1'b0;
      wr_strobe   <= 1'b0;
      reg_addr    <= 5'h00;
      wr_data     <= 16'h0000;
    end else begin
      rd_strobe <= 1'b0;
      wr_strobe <= 1'b0;
      if (mdc_rise) begin
        unique case (state_reg)
          S_PRE: begin
            if (bit_in) begin
              if (pre_cnt_reg != 6'(`MDIO_PREAMBLE_BITS)) pre_cnt_reg <= pre_cnt_reg + 6'h01;
            end else if (pre_cnt_reg == 6'(`MDIO_PREAMBLE_BITS) || preamble_suppress) begin
              state_reg <= S_START; // [RULE_10]
            end else begin
              pre_cnt_reg <= 6'h00;
            end
          end
          S_START: begin
            state_reg   <= bit_in ? S_HEAD : S_PRE;
            bit_cnt_reg <= 5'h00;
            pre_cnt_reg <= 6'h00;
          end
          S_HEAD: begin
            head_reg    <= {head_reg[12:0], bit_in};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'd11) begin
              read_op_reg <= head_reg[10:9] == 2'b10;
              match_reg   <= head_reg[8:4] == mgmt_station_address; // [RULE_21]
              reg_addr    <= {head_reg[3:0], bit_in};
              state_reg   <= (head_reg[10] ^ head_reg[9]) ? S_TA : S_PRE;
              bit_cnt_reg <= 5'h00;
            end
          end
          S_TA: begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'd1) begin
              state_reg   <= S_DATA;
              bit_cnt_reg <= 5'h00;
              shift_reg   <= rd_data;
              rd_strobe   <= read_op_reg && match_reg;
            end
          end
          S_DATA: begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            shift_reg   <= {shift_reg[14:0], bit_in};
            if (bit_cnt_reg == 5'd15) begin
              state_reg <= S_PRE;
              wr_data   <= {shift_reg[14:0], bit_in};
              wr_strobe <= !read_op_reg && match_reg;
            end
          end
          default: state_reg <= S_PRE;
        endcase
      end
    end
  end

  // Read data leaves on falling edges; drive ends with the frame's last bit.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mdio_out <= 1'b1;
      mdio_oe  <= 1'b0;
    end else if (mdc_fall) begin
      if (state_reg == S_TA && bit_cnt_reg == 5'd1 && read_op_reg && match_reg) begin
        mdio_oe  <= 1'b1;
        mdio_out <= 1'b0;
      end else if (state_reg == S_DATA && read_op_reg && match_reg) begin
        mdio_oe  <= 1'b1;
        mdio_out <= shift_reg[15];
      end else begin
        mdio_oe  <= 1'b0;
        mdio_out <= 1'b1;
      end
    end
  end
endmodule

// ==== hw/phy_mode_aux_register_bank.sv ====
// Mode and auxiliary register bank of the transceiver, reached over the management link.
`timescale 1ns/1ps
`include "phy_regs_defs.svh"
module phy_mode_aux_register_bank (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic [4:0]  addr_strap,
  input  wire logic        fibre_mode_flag,
  input  wire logic        an_enable_req,
  input  wire logic        an_complete,
  input  wire logic        an_ack_done,
  input  wire logic        an_ack_match,
  input  wire logic        an_ability_detect,
  input  wire logic        local_sym_pause,
  input  wire logic        partner_sym_pause,
  input  wire logic [2:0]  highest_common_mode,
  input  wire logic        link_speed_100,
  input  wire logic        link_full_duplex,
  input  wire logic        link_up,
  input  wire logic        twisted_pair_10,
  input  wire logic        rx_error_event,
  input  wire logic        tx_request,
  input  wire logic        jabber_timeout,
  output logic             rx_err_count_en,
  output logic             dc_restore_en,
  output logic             nrzi_conv_en,
  output logic             tx_isolate,
  output logic             mlt3_bypass,
  output logic             scrambler_bypass,
  output logic             an_enabled,
  output logic             jabber_cutoff,
  output logic             mdc_internal_en,
  output logic [15:0]      rx_error_count
);
  logic        rd_strobe;
  logic        wr_strobe;
  logic [4:0]  reg_addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic        mdc_active;
  logic [15:0] lc_reg;
  logic [15:0] rm_reg;
  logic [15:0] ac_reg;
  logic        ack_flag_reg;
  logic        match_flag_reg;
  logic        abil_flag_reg;
  logic        strap_pend_reg;
  logic [1:0]  fibre_sync_reg;
  logic [1:0]  an_req_sync_reg;
  logic [6:0]  ev_sync1_reg;
  logic [6:0]  ev_sync2_reg;
  logic [6:0]  ev_prev_reg;
  logic        fibre_s;
  logic        an_en_s;
  logic        an_done_s;
  logic        rx_err_rise;
  phy_regs_pkg::op_mode_type op_mode_indication;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame engine.

  mdio_serial_engine u_engine (
    .sys_clk              (sys_clk),
    .rstn                 (rstn),
    .mdc_pin              (mdc),
    .mdio_in_pin          (mdio_in),
    .mgmt_station_address (rm_reg[`RM_ADDR_LSB +: 5]),
    .preamble_suppress    (rm_reg[`RM_PRE_SUP_BIT]),
    .clock_gate_en        (ac_reg[`AC_MDIO_PS_BIT]),
    .rd_data              (rd_data),
    .rd_strobe            (rd_strobe),
    .wr_strobe            (wr_strobe),
    .reg_addr             (reg_addr),
    .wr_data              (wr_data),
    .mdio_out             (mdio_out),
    .mdio_oe              (mdio_oe),
    .mdc_active           (mdc_active)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Negotiation, pause, error and fibre inputs cross in through two flops each; link, common-mode and jabber inputs do not.

  // Bundle: ack done, ack match, ability, negotiation done, rx error, pause pair.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fibre_sync_reg  <= 2'h0;
      an_req_sync_reg <= 2'h0;
      ev_sync1_reg    <= 7'h00;
      ev_sync2_reg    <= 7'h00;
      ev_prev_reg     <= 7'h00;
    end else begin
      fibre_sync_reg  <= {fibre_sync_reg[0], fibre_mode_flag};
      an_req_sync_reg <= {an_req_sync_reg[0], an_enable_req};
      ev_sync1_reg    <= {an_ack_done, an_ack_match, an_ability_detect, an_complete,
                          rx_error_event, local_sym_pause, partner_sym_pause};
      ev_sync2_reg    <= ev_sync1_reg;
      ev_prev_reg     <= ev_sync2_reg;
    end
  end
  assign fibre_s     = fibre_sync_reg[1];
  assign an_en_s     = an_req_sync_reg[1] && !fibre_s; // [RULE_20]
  assign an_done_s   = ev_sync2_reg[3] && an_en_s;     // [RULE_02]
  assign rx_err_rise = ev_sync2_reg[2] && !ev_prev_reg[2];

  // Current mode code, isolation taking precedence over link results.
  always_comb begin
    if (lc_reg[`LC_TX_ISO_BIT])
      op_mode_indication = phy_regs_pkg::MODE_TX_ISOLATE;
    else if (an_en_s && !an_done_s)
      op_mode_indication = phy_regs_pkg::MODE_NEGOTIATING;
    else if (link_speed_100)
      op_mode_indication = link_full_duplex ? phy_regs_pkg::MODE_100_FULL
                                            : phy_regs_pkg::MODE_100_HALF;
    else
      op_mode_indication = link_full_duplex ? phy_regs_pkg::MODE_10_FULL
                                            : phy_regs_pkg::MODE_10_HALF;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers.

  // Masked writes keep reserved and read-only bits at their defaults.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lc_reg <= `LC_RESET;
      ac_reg <= `AC_RESET;
    end else if (wr_strobe) begin
      if (reg_addr == `LINE_CODING_ADDR)
        lc_reg <= (wr_data & `LC_RW_MASK) | (`LC_RESET & ~`LC_RW_MASK); // [RULE_22]
      if (reg_addr == `AUX_CTRL_ADDR)
        ac_reg <= (wr_data & `AC_RW_MASK) | (`AC_RESET & ~`AC_RW_MASK); // [RULE_12]
    end
  end

  // Straps cannot enter an async reset, so they load on the first clock after release.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rm_reg         <= `RM_RESET;
      strap_pend_reg <= 1'b1;
    end else if (strap_pend_reg) begin
      strap_pend_reg <= 1'b0;
      rm_reg[`RM_ADDR_LSB +: 5] <= addr_strap; // [RULE_09]
    end else if (wr_strobe && reg_addr == `RX_MODE_ADDR) begin
      rm_reg <= (wr_data & `RM_RW_MASK) | (`RM_RESET & ~`RM_RW_MASK); // [RULE_10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latching-high flags; the event wins over a read in the same cycle.

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_flag_reg   <= 1'b0;
      match_flag_reg <= 1'b0;
      abil_flag_reg  <= 1'b0;
    end else begin
      if (ev_sync2_reg[6])
        ack_flag_reg <= 1'b1; // [RULE_14]
      else if (rd_strobe && reg_addr == `AUX_STATUS_ADDR)
        ack_flag_reg <= 1'b0; // [RULE_19]
      if (ev_sync2_reg[5])
        match_flag_reg <= 1'b1; // [RULE_15]
      else if (rd_strobe && reg_addr == `AUX_STATUS_ADDR)
        match_flag_reg <= 1'b0; // [RULE_19]
      if (ev_sync2_reg[4])
        abil_flag_reg <= 1'b1; // [RULE_16]
      else if (rd_strobe && reg_addr == `AUX_STATUS_ADDR)
        abil_flag_reg <= 1'b0; // [RULE_19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; the engine captures it at the turnaround edge.

  always_comb begin
    rd_data = 16'h0000;
    unique case (reg_addr)
      `LINE_CODING_ADDR: begin
        rd_data = lc_reg;
        rd_data[`LC_AN_DONE_BIT] = an_done_s;                      // [RULE_02]
        rd_data[`LC_MODE_LSB +: 3] = op_mode_indication;           // [RULE_06]
      end
      `RX_MODE_ADDR: rd_data = rm_reg;
      `AUX_CTRL_ADDR: rd_data = ac_reg;                            // [RULE_12]
      `AUX_STATUS_ADDR: begin
        rd_data[`AS_AN_DONE_BIT]  = an_done_s;                     // [RULE_02]
        rd_data[`AS_AN_ACK_BIT]   = ack_flag_reg;
        rd_data[`AS_AN_MATCH_BIT] = match_flag_reg;
        rd_data[`AS_AN_ABIL_BIT]  = abil_flag_reg;
        rd_data[`AS_PAUSE_BIT]    = an_done_s && ev_sync2_reg[1] && ev_sync2_reg[0]; // [RULE_17]
        rd_data[`AS_HCM_LSB +: 3] = an_done_s ? highest_common_mode : 3'h0;          // [RULE_18]
      end
      default: rd_data = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controls to the datapath, all registered.

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_err_count_en  <= 1'b1;
      dc_restore_en    <= 1'b1;
      nrzi_conv_en     <= 1'b1;
      tx_isolate       <= 1'b0;
      mlt3_bypass      <= 1'b0;
      scrambler_bypass <= 1'b0;
      an_enabled       <= 1'b0;
      jabber_cutoff    <= 1'b0;
      mdc_internal_en  <= 1'b1;
    end else begin
      rx_err_count_en  <= !lc_reg[`LC_RXERR_DIS_BIT];               // [RULE_01]
      dc_restore_en    <= lc_reg[`LC_DC_REST_BIT];                  // [RULE_03]
      nrzi_conv_en     <= lc_reg[`LC_NRZI_BIT];                     // [RULE_04]
      tx_isolate       <= lc_reg[`LC_TX_ISO_BIT];                   // [RULE_05]
      mlt3_bypass      <= lc_reg[`LC_MLT3_DIS_BIT];                 // [RULE_07]
      scrambler_bypass <= lc_reg[`LC_SCR_DIS_BIT] || fibre_s;       // [RULE_08]
      an_enabled       <= an_en_s;                                  // [RULE_20]
      // Jabber only guards 10 Mb/s twisted pair and may be switched off by software.
      jabber_cutoff    <= twisted_pair_10 && tx_request && jabber_timeout &&
                          !ac_reg[`AC_JAB_DIS_BIT];                 // [RULE_11]
      mdc_internal_en  <= mdc_active;                               // [RULE_13]
    end
  end

  // Receive error counter; saturates rather than wraps so a full count stays visible.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      rx_error_count <= 16'h0000;
    else if (rx_err_rise && !lc_reg[`LC_RXERR_DIS_BIT] && rx_error_count != 16'hFFFF)
      rx_error_count <= rx_error_count + 16'h0001; // [RULE_01]
  end
endmodule

// ==== testbench/phy_bank_chk.sv ====
// Concurrent checks on the ports of the mode and auxiliary register bank.
`timescale 1ns/1ps
module phy_bank_chk (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        fibre_mode_flag,
  input wire logic        an_enable_req,
  input wire logic        twisted_pair_10,
  input wire logic        mdio_out,
  input wire logic        mdio_oe,
  input wire logic        rx_err_count_en,
  input wire logic        scrambler_bypass,
  input wire logic        an_enabled,
  input wire logic        jabber_cutoff,
  input wire logic [15:0] rx_error_count
);
  logic [7:0] oe_cnt;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  // Length of the current drive burst; a read answer spans 17 link clock periods.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      oe_cnt <= 8'h00;
    end else if (mdio_oe) begin
      oe_cnt <= oe_cnt + 8'h01;
    end else begin
      oe_cnt <= 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_fibre_scr_off: assert property (fibre_mode_flag [*4] |-> scrambler_bypass)
    else $error("scrambler active in fibre mode");
  chk_fibre_an_off: assert property (fibre_mode_flag [*4] |-> !an_enabled)
    else $error("negotiation active in fibre mode");
  chk_an_req_off: assert property (!an_enable_req [*4] |-> !an_enabled)
    else $error("negotiation enabled without request");
  chk_jab_tp_only: assert property (!twisted_pair_10 |=> !jabber_cutoff)
    else $error("jabber cutoff outside 10 Mb/s twisted pair");
  chk_ta_drive_low: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround not driven low");
  chk_drive_len: assert property ($fell(mdio_oe) |-> oe_cnt >= 8'd132 && oe_cnt <= 8'd140)
    else $error("read answer of wrong length");
  chk_drive_bound: assert property (oe_cnt <= 8'd140)
    else $error("data line driven too long");
  chk_count_frozen: assert property (!rx_err_count_en && $past(!rx_err_count_en) |-> $stable(rx_error_count))
    else $error("error count moved while disabled");
  chk_count_step: assert property ($changed(rx_error_count) |-> rx_error_count == $past(rx_error_count) + 16'h0001)
    else $error("error count jumped");
  cover property ($rose(mdio_oe));
  cover property ($rose(jabber_cutoff));
  cover property ($rose(scrambler_bypass));
  cover property ($changed(rx_error_count));
endmodule
bind phy_mode_aux_register_bank phy_bank_chk u_chk (.sys_clk, .rstn, .fibre_mode_flag,
  .an_enable_req, .twisted_pair_10, .mdio_out, .mdio_oe, .rx_err_count_en,
  .scrambler_bypass, .an_enabled, .jabber_cutoff, .rx_error_count);

// ==== testbench/mdio_station.sv ====
// Station management model that frames reads and writes on the management link.
`timescale 1ns/1ps
module mdio_station (
  output logic       mdc,
  output logic       sta_out,
  output logic       sta_oe,
  input  wire logic  line
);
  logic smp;
  // The link clock rests low between frames; the line falls to its pull-up.
  initial begin
    mdc = 1'b0;
    sta_out = 1'b1;
    sta_oe = 1'b0;
  end
  // Data moves at the falling edge; sampling late in the high phase clears the device's lag.
  task automatic slot(input logic b);
    sta_out = b;
    #160 mdc = 1'b1;
    #150 smp = line;
    #10 mdc = 1'b0;
  endtask
  // One whole frame; a read hands back what the line carried after turnaround.
  task automatic xfer(input logic pre, input logic [1:0] op, input logic [4:0] pa,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd, output logic ta_ok);
    logic [13:0] hdr;
    hdr = {2'b01, op, pa, ra};
    rd = 16'hFFFF;
    ta_ok = 1'b0;
    sta_oe = 1'b1;
    if (pre) for (int i = 0; i < 32; i++) slot(1'b1);
    for (int i = 13; i >= 0; i--) slot(hdr[i]);
    if (op == 2'b01) begin
      slot(1'b1);
      slot(1'b0);
      for (int i = 15; i >= 0; i--) slot(wd[i]);
    end else begin
      sta_oe = 1'b0;
      slot(1'b1);
      slot(1'b1);
      ta_ok = (smp === 1'b0);
      for (int i = 15; i >= 0; i--) begin
        slot(1'b1);
        rd[i] = smp;
      end
    end
    sta_oe = 1'b0;
    sta_out = 1'b1;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the mode and auxiliary register bank.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module tb_top;
  logic        sys_clk, rstn, mdc, mdio_in, mdio_out, mdio_oe, sta_out, sta_oe;
  logic        fibre_mode_flag, an_enable_req, an_complete, an_ack_done, an_ack_match;
  logic        an_ability_detect, local_sym_pause, partner_sym_pause, link_speed_100;
  logic        link_full_duplex, link_up, twisted_pair_10, rx_error_event, tx_request;
  logic        jabber_timeout, rx_err_count_en, dc_restore_en, nrzi_conv_en, tx_isolate;
  logic        mlt3_bypass, scrambler_bypass, an_enabled, jabber_cutoff, mdc_internal_en;
  logic [4:0]  addr_strap, phy;
  logic [2:0]  highest_common_mode;
  logic [15:0] rx_error_count;
  logic [2:0]  mode_tab [4] = '{3'b001, 3'b101, 3'b010, 3'b110};
  logic [2:0]  hcm_tab [4] = '{3'b001, 3'b010, 3'b011, 3'b101};
  int          miscompares, check_count, cyc;
  // Device, else station, else pull-up drives the line.
  assign mdio_in = mdio_oe ? mdio_out : (sta_oe ? sta_out : 1'b1);
  mdio_station u_sta (.mdc(mdc), .sta_out(sta_out), .sta_oe(sta_oe), .line(mdio_in));
  phy_mode_aux_register_bank u_dut (.sys_clk, .rstn, .mdc, .mdio_in, .mdio_out, .mdio_oe,
    .addr_strap, .fibre_mode_flag, .an_enable_req, .an_complete, .an_ack_done,
    .an_ack_match, .an_ability_detect, .local_sym_pause, .partner_sym_pause,
    .highest_common_mode, .link_speed_100, .link_full_duplex, .link_up, .twisted_pair_10,
    .rx_error_event, .tx_request, .jabber_timeout, .rx_err_count_en, .dc_restore_en,
    .nrzi_conv_en, .tx_isolate, .mlt3_bypass, .scrambler_bypass, .an_enabled,
    .jabber_cutoff, .mdc_internal_en, .rx_error_count);
  ////////////////////////////////////////////////////////////////////////////////
  always #20 sys_clk = ~sys_clk;
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] r;
    logic        ok;
    u_sta.xfer(1'b1, 2'b01, phy, ra, wd, r, ok);
    step(8);
  endtask
  task automatic rd_chk(input logic pre, input logic [4:0] ra, input logic [15:0] e,
                        input logic e_ok);
    logic [15:0] r;
    logic        ok;
    u_sta.xfer(pre, 2'b10, phy, ra, 16'h0000, r, ok);
    `CHK(ok, e_ok)
    `CHK(r, e)
    step(8);
  endtask
  // Each event is held long enough to cross the synchroniser once.
  task automatic pulse_err(input logic [15:0] e);
    rx_error_event = 1'b1;
    step(4);
    rx_error_event = 1'b0;
    step(4);
    `CHK(rx_error_count, e)
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Ceiling well above the run's length.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_clk, rstn, fibre_mode_flag, an_complete, an_ack_done, an_ack_match} = 6'h00;
    {an_ability_detect, partner_sym_pause, link_speed_100, link_full_duplex} = 4'h0;
    {link_up, twisted_pair_10, rx_error_event, tx_request, jabber_timeout} = 5'h00;
    {an_enable_req, local_sym_pause, highest_common_mode} = 5'h18;
    addr_strap = 5'h05;
    phy = 5'h05;
    step(20);
    rstn = 1'b1;
    step(4);
    rd_chk(1'b1, 5'h13, 16'h01C0, 1'b1);
    rd_chk(1'b1, 5'h14, 16'h002A, 1'b1);
    rd_chk(1'b1, 5'h18, 16'h0027, 1'b1);
    rd_chk(1'b1, 5'h19, 16'h0000, 1'b1);
    rd_chk(1'b1, 5'h15, 16'h0000, 1'b1);
    `CHK({rx_err_count_en, dc_restore_en, nrzi_conv_en, tx_isolate, mlt3_bypass, scrambler_bypass, an_enabled, mdc_internal_en}, 8'hE3)
    pulse_err(16'h0001);
    wr(5'h13, 16'hFFFF);
    rd_chk(1'b1, 5'h13, 16'h2FFF, 1'b1);
    `CHK({rx_err_count_en, dc_restore_en, nrzi_conv_en, tx_isolate, mlt3_bypass, scrambler_bypass}, 6'h1F)
    pulse_err(16'h0001);
    wr(5'h13, 16'h0000);
    rd_chk(1'b1, 5'h13, 16'h0000, 1'b1);
    `CHK({rx_err_count_en, dc_restore_en, nrzi_conv_en, tx_isolate, mlt3_bypass, scrambler_bypass}, 6'h20)
    pulse_err(16'h0002);
    wr(5'h14, 16'h0052);
    rd_chk(1'b1, 5'h14, 16'hFFFF, 1'b0);
    wr(5'h13, 16'h0001);
    phy = 5'h0A;
    rd_chk(1'b0, 5'h13, 16'h0000, 1'b1);
    wr(5'h14, 16'h0050);
    rd_chk(1'b0, 5'h14, 16'hFFFF, 1'b0);
    rd_chk(1'b1, 5'h14, 16'h0050, 1'b1);
    {twisted_pair_10, tx_request, jabber_timeout} = 3'h7;
    step(3);
    `CHK(jabber_cutoff, 1'b1)
    wr(5'h18, 16'hC0E0);
    `CHK(jabber_cutoff, 1'b0)
    rd_chk(1'b1, 5'h18, 16'hC0E7, 1'b1);
    wr(5'h18, 16'h0020);
    rd_chk(1'b1, 5'h18, 16'h0027, 1'b1);
    `CHK(jabber_cutoff, 1'b1)
    twisted_pair_10 = 1'b0;
    step(2);
    `CHK(jabber_cutoff, 1'b0)
    // Pulsed events are gone before the reads, so the second read sees them cleared.
    {an_complete, partner_sym_pause, an_ack_done, an_ack_match, an_ability_detect} = 5'h1F;
    {link_speed_100, link_full_duplex, highest_common_mode} = 5'h1D;
    step(4);
    {an_ack_done, an_ack_match, an_ability_detect} = 3'h0;
    step(4);
    rd_chk(1'b1, 5'h19, 16'hFD00, 1'b1);
    rd_chk(1'b1, 5'h19, 16'h8D00, 1'b1);
    for (int i = 0; i < 4; i++) begin
      {link_speed_100, link_full_duplex} = i[1:0];
      highest_common_mode = hcm_tab[i];
      rd_chk(1'b1, 5'h13, {4'h1, 7'h00, mode_tab[i], 2'b00}, 1'b1);
      rd_chk(1'b1, 5'h19, {5'b10001, hcm_tab[i], 8'h00}, 1'b1);
    end
    partner_sym_pause = 1'b0;
    rd_chk(1'b1, 5'h19, 16'h8500, 1'b1);
    fibre_mode_flag = 1'b1;
    step(5);
    `CHK({an_enabled, scrambler_bypass}, 2'b01)
    rd_chk(1'b1, 5'h19, 16'h0000, 1'b1);
    fibre_mode_flag = 1'b0;
    an_enable_req = 1'b0;
    step(6);
    rd_chk(1'b1, 5'h13, 16'h0018, 1'b1);
    summarize();
  end
endmodule
